//--- pkg/uacp_params.svh
// Constants for the cell port: sizes, idle values and reset values
`ifndef UACP_PARAMS_SVH
`define UACP_PARAMS_SVH

// Bytes in one cell and width of the byte index
`define UACP_CELL_BYTES 53
`define UACP_IDX_W      6

// Link widths
`define UACP_ADDR_W     5
`define UACP_BYTE_W     8

// Address driven while no PHY is polled or selected
`define UACP_IDLE_ADDR  5'h1F

// Reset values of link outputs
`define UACP_EN_B_RST   1'b1
`define UACP_OE_B_RST   1'b1

`endif

//--- pkg/uacp_pkg.sv
// Types shared by the cell port modules
package uacp_pkg;

   // Transmit link states
   typedef enum logic [2:0] {
      TX_IDLE, TX_POLL, TX_WAIT, TX_SELECT, TX_SEND
   } uacp_tx_state_e;

   // Receive link states
   typedef enum logic [2:0] {
      RX_IDLE, RX_POLL, RX_WAIT, RX_SELECT, RX_RECV
   } uacp_rx_state_e;

endpackage

//--- rtl/uacp_cell_mem.sv
// Two-clock cell memory with a registered read port
`timescale 1ns/100ps
`include "uacp_params.svh"

module uacp_cell_mem
#(
   parameter int DW = `UACP_BYTE_W,
   parameter int AW = `UACP_IDX_W
)
(
   // Write side
   input  wire logic          wr_clock,
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [DW-1:0] wr_data,
   // Read side
   input  wire logic          rd_clock,
   input  wire logic          rd_rst_b,
   input  wire logic [AW-1:0] rd_addr,
   output logic      [DW-1:0] rd_data
);

   logic [DW-1:0] store [0:(1<<AW)-1];

   // Array has no reset; a cell is always written before it is read
   always_ff @(posedge wr_clock)
   begin
      if (wr_en)
         store[wr_addr] <= wr_data;
   end

   // Registered read keeps output timing clean in the read domain
   always_ff @(posedge rd_clock or negedge rd_rst_b)
   begin
      if (!rd_rst_b)
         rd_data <= '0;
      else
         rd_data <= store[rd_addr];
   end

endmodule

//--- rtl/uacp_port.sv
// Cell port: ATM-layer transmit and receive ends, SPHY and MPHY polling
//
// Behaviour
// RULE1: Transmit outputs launched on transmit clock rising edge
// RULE2: Receive inputs sampled on receive clock rising edge
// RULE3: MPHY select: address with enable high, then low
// RULE4: Transmit enable asserted while cell bytes transfer
// RULE5: SPHY transmit enable means ready to send
// RULE6: Start-of-cell high exactly with first byte
// RULE7: Outgoing cell over 8-bit bus, byte per transfer
// RULE8: MPHY drives 5-bit transmit address, one PHY
// RULE9: Polled PHY reports space one clock after address
// RULE10: PHYs share space line with tri-state drivers
// RULE11: Polled PHY reports cell one clock after address
// RULE12: SPHY receive available flag means data ready
// RULE13: MPHY receive enable picks the driving PHY
// RULE14: SPHY receive enable means ready to accept
// RULE15: PHY marks first received byte with start-of-cell
// RULE16: Transfer only after flag reports full cell
// RULE17: Outside MPHY, addresses held at fixed value
`timescale 1ns/100ps
`include "uacp_params.svh"

module uacp_port
   import uacp_pkg::*;
#(
   parameter int CELL_BYTES = `UACP_CELL_BYTES,
   parameter int IDX_W      = `UACP_IDX_W
)
(
   // System clock and reset
   input  wire logic             clock,
   input  wire logic             rst_b,
   // Configuration, latched at each start
   input  wire logic             mphy_mode,
   input  wire logic [4:0]       tx_phy_sel,
   input  wire logic [4:0]       rx_phy_sel,
   // Transmit user side
   input  wire logic             tx_wr_en,
   input  wire logic [IDX_W-1:0] tx_wr_addr,
   input  wire logic [7:0]       tx_wr_byte,
   input  wire logic             tx_start,
   output logic                  tx_busy,
   // Receive user side
   input  wire logic             rx_start,
   output logic                  rx_busy,
   input  wire logic [IDX_W-1:0] rx_rd_addr,
   output logic      [7:0]       rx_rd_byte,
   // Transmit link
   input  wire logic             cell_tx_clock,
   output logic                  cell_tx_enable_out_b,
   output logic                  cell_tx_start_of_cell,
   output logic      [7:0]       cell_tx_byte_bus,
   output logic      [4:0]       cell_tx_phy_address,
   output logic                  cell_tx_phy_address_oe_b,
   input  wire logic             cell_tx_space_flag,
   // Receive link
   input  wire logic             cell_rx_clock,
   output logic                  cell_rx_enable_out_b,
   output logic      [4:0]       cell_rx_phy_address,
   output logic                  cell_rx_phy_address_oe_b,
   input  wire logic             cell_rx_available_flag,
   input  wire logic             cell_rx_start_of_cell,
   input  wire logic [7:0]       cell_rx_byte_bus
);

   localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(CELL_BYTES);

   // Address to drive: the chosen PHY in every state but idle, in MPHY mode only
   function automatic logic [4:0] pick_addr(input logic mode,
                                            input logic active,
                                            input logic [4:0] sel);
      pick_addr = (mode && active) ? sel : `UACP_IDLE_ADDR;
   endfunction

   // ---------------- System domain ----------------
   logic       tx_req_tgl, tx_ack_s1, tx_ack_s2, tx_mode_hold;
   logic       rx_req_tgl, rx_ack_s1, rx_ack_s2, rx_mode_hold;
   logic [4:0] tx_sel_hold, rx_sel_hold;
   logic       tx_done_tgl, rx_done_tgl;

   // A start is taken only while idle; holds stay still while busy
   wire tx_accept    = tx_start && !tx_busy;
   wire rx_accept    = rx_start && !rx_busy;
   wire next_tx_busy = tx_accept || (tx_req_tgl != tx_ack_s2);
   wire next_rx_busy = rx_accept || (rx_req_tgl != rx_ack_s2);

   // Request toggles out, done toggles back through two flops
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         {tx_req_tgl, tx_ack_s1, tx_ack_s2, tx_busy} <= 4'h0;
         {rx_req_tgl, rx_ack_s1, rx_ack_s2, rx_busy} <= 4'h0;
         {tx_mode_hold, rx_mode_hold}                <= 2'h0;
         tx_sel_hold <= `UACP_IDLE_ADDR;
         rx_sel_hold <= `UACP_IDLE_ADDR;
      end
      else
      begin
         tx_req_tgl   <= tx_req_tgl ^ tx_accept;
         rx_req_tgl   <= rx_req_tgl ^ rx_accept;
         tx_mode_hold <= tx_accept ? mphy_mode : tx_mode_hold;
         rx_mode_hold <= rx_accept ? mphy_mode : rx_mode_hold;
         tx_sel_hold  <= tx_accept ? tx_phy_sel : tx_sel_hold;
         rx_sel_hold  <= rx_accept ? rx_phy_sel : rx_sel_hold;
         tx_ack_s1    <= tx_done_tgl;
         tx_ack_s2    <= tx_ack_s1;
         rx_ack_s1    <= rx_done_tgl;
         rx_ack_s2    <= rx_ack_s1;
         tx_busy      <= next_tx_busy;
         rx_busy      <= next_rx_busy;
      end
   end

   // ---------------- Transmit link domain ----------------
   uacp_tx_state_e   tx_state, next_tx_state;
   logic             tx_req_s1, tx_req_s2, tx_req_s3, tx_mode_q;
   logic [4:0]       tx_sel_q;
   logic [IDX_W-1:0] tx_idx;

   wire tx_go   = tx_req_s2 ^ tx_req_s3;
   wire tx_last = (tx_idx == LAST_IDX);

   // Poll, wait a clock for the flag, select, then stream the cell
   always_comb
   begin
      next_tx_state = tx_state;
      case (tx_state)
         TX_IDLE:   if (tx_go)
                       next_tx_state = tx_mode_hold ? TX_POLL : TX_WAIT;
         TX_POLL:   next_tx_state = TX_WAIT;
         TX_WAIT:   if (cell_tx_space_flag) // see RULE9 see RULE16
                       next_tx_state = TX_SELECT;
                    else
                       next_tx_state = tx_mode_q ? TX_POLL : TX_WAIT;
         TX_SELECT: next_tx_state = TX_SEND; // see RULE3
         TX_SEND:   if (tx_last)
                       next_tx_state = TX_IDLE;
         default:   next_tx_state = TX_IDLE;
      endcase
   end

   wire             next_tx_mode = tx_go ? tx_mode_hold : tx_mode_q;
   wire [4:0]       next_tx_sel  = tx_go ? tx_sel_hold : tx_sel_q;
   wire             tx_sending   = (next_tx_state == TX_SEND);
   wire [IDX_W-1:0] next_tx_idx  = tx_sending ? tx_idx + 1'b1 : '0;
   wire [4:0]       next_tx_addr = pick_addr(next_tx_mode,
                        next_tx_state != TX_IDLE, next_tx_sel);
   wire             next_tx_soc  = tx_sending && (tx_state == TX_SELECT);

   // Every link output but the byte bus launches from this rising-edge process
   always_ff @(posedge cell_tx_clock or negedge rst_b) // see RULE1
   begin
      if (!rst_b)
      begin
         tx_state <= TX_IDLE;
         {tx_req_s1, tx_req_s2, tx_req_s3, tx_mode_q} <= 4'h0;
         tx_sel_q    <= `UACP_IDLE_ADDR;
         tx_idx      <= '0;
         tx_done_tgl <= 1'b0;
         cell_tx_enable_out_b     <= `UACP_EN_B_RST;
         cell_tx_start_of_cell    <= 1'b0;
         cell_tx_phy_address      <= `UACP_IDLE_ADDR;
         cell_tx_phy_address_oe_b <= `UACP_OE_B_RST;
      end
      else
      begin
         tx_req_s1   <= tx_req_tgl;
         tx_req_s2   <= tx_req_s1;
         tx_req_s3   <= tx_req_s2;
         tx_state    <= next_tx_state;
         tx_mode_q   <= next_tx_mode;
         tx_sel_q    <= next_tx_sel;
         tx_idx      <= next_tx_idx;
         tx_done_tgl <= tx_done_tgl ^ ((tx_state == TX_SEND) && tx_last);
         cell_tx_enable_out_b     <= !tx_sending; // see RULE4 see RULE5
         cell_tx_start_of_cell    <= next_tx_soc; // see RULE6
         cell_tx_phy_address      <= next_tx_addr; // see RULE8 see RULE17
         cell_tx_phy_address_oe_b <= 1'b0;
      end
   end

   // Cell bytes are read one clock ahead so the bus changes with enable
   uacp_cell_mem #(.DW(8), .AW(IDX_W)) u_tx_mem
   (
      .wr_clock (clock),
      .wr_en    (tx_wr_en),
      .wr_addr  (tx_wr_addr),
      .wr_data  (tx_wr_byte),
      .rd_clock (cell_tx_clock),
      .rd_rst_b (rst_b),
      .rd_addr  (tx_idx),
      .rd_data  (cell_tx_byte_bus) // see RULE7
   );

   // ---------------- Receive link domain ----------------
   uacp_rx_state_e   rx_state, next_rx_state;
   logic             rx_req_s1, rx_req_s2, rx_req_s3, rx_mode_q;
   logic [4:0]       rx_sel_q;
   logic [IDX_W-1:0] rx_idx;
   logic             rx_soc_q, rx_en_d1, rx_en_d2;
   logic [7:0]       rx_byte_q;

   wire rx_go   = rx_req_s2 ^ rx_req_s3;
   wire rx_last = (rx_idx == LAST_IDX);

   // Same polling walk as transmit; stays in RECV until cell is stored
   always_comb
   begin
      next_rx_state = rx_state;
      case (rx_state)
         RX_IDLE:   if (rx_go)
                       next_rx_state = rx_mode_hold ? RX_POLL : RX_WAIT;
         RX_POLL:   next_rx_state = RX_WAIT;
         RX_WAIT:   if (cell_rx_available_flag) // see RULE11 see RULE16
                       next_rx_state = RX_SELECT;
                    else
                       next_rx_state = rx_mode_q ? RX_POLL : RX_WAIT;
         RX_SELECT: next_rx_state = RX_RECV;
         RX_RECV:   if (rx_last)
                       next_rx_state = RX_IDLE;
         default:   next_rx_state = RX_IDLE;
      endcase
   end

   wire             next_rx_mode = rx_go ? rx_mode_hold : rx_mode_q;
   wire [4:0]       next_rx_sel  = rx_go ? rx_sel_hold : rx_sel_q;
   wire             rx_taking    = (next_rx_state == RX_RECV);
   wire [4:0]       next_rx_addr = pick_addr(next_rx_mode,
                        next_rx_state != RX_IDLE, next_rx_sel);
   // A byte counts once enable was low two clocks back and a cell began
   wire rx_wr = (rx_state == RX_RECV) && rx_en_d2 && !rx_last
                && (rx_soc_q || (rx_idx != '0)); // see RULE15
   wire [IDX_W-1:0] next_rx_idx  = (rx_state == RX_RECV)
                                   ? rx_idx + IDX_W'(rx_wr) : '0;

   // Pins sampled straight on the receive edge; they share this clock
   always_ff @(posedge cell_rx_clock or negedge rst_b) // see RULE2
   begin
      if (!rst_b)
      begin
         rx_state <= RX_IDLE;
         {rx_req_s1, rx_req_s2, rx_req_s3, rx_mode_q} <= 4'h0;
         {rx_soc_q, rx_en_d1, rx_en_d2, rx_done_tgl}  <= 4'h0;
         rx_sel_q  <= `UACP_IDLE_ADDR;
         rx_idx    <= '0;
         rx_byte_q <= 8'h00;
         cell_rx_enable_out_b     <= `UACP_EN_B_RST;
         cell_rx_phy_address      <= `UACP_IDLE_ADDR;
         cell_rx_phy_address_oe_b <= `UACP_OE_B_RST;
      end
      else
      begin
         rx_req_s1   <= rx_req_tgl;
         rx_req_s2   <= rx_req_s1;
         rx_req_s3   <= rx_req_s2;
         rx_state    <= next_rx_state;
         rx_mode_q   <= next_rx_mode;
         rx_sel_q    <= next_rx_sel;
         rx_idx      <= next_rx_idx;
         rx_soc_q    <= cell_rx_start_of_cell;
         rx_byte_q   <= cell_rx_byte_bus;
         rx_en_d1    <= !cell_rx_enable_out_b;
         rx_en_d2    <= rx_en_d1;
         rx_done_tgl <= rx_done_tgl ^ ((rx_state == RX_RECV) && rx_last);
         cell_rx_enable_out_b     <= !rx_taking; // see RULE13 see RULE14
         cell_rx_phy_address      <= next_rx_addr; // see RULE17
         cell_rx_phy_address_oe_b <= 1'b0;
      end
   end

   // Received cell is parked here for the system side to read
   uacp_cell_mem #(.DW(8), .AW(IDX_W)) u_rx_mem
   (
      .wr_clock (cell_rx_clock),
      .wr_en    (rx_wr),
      .wr_addr  (rx_idx),
      .wr_data  (rx_byte_q),
      .rd_clock (clock),
      .rd_rst_b (rst_b),
      .rd_addr  (rx_rd_addr),
      .rd_data  (rx_rd_byte)
   );

   // ---------------- Checks ----------------
   logic [IDX_W:0] tx_low_cnt;

   // Counts enable-low clocks of the current transmit burst
   always_ff @(posedge cell_tx_clock or negedge rst_b)
   begin
      if (!rst_b)
         tx_low_cnt <= '0;
      else
         tx_low_cnt <= cell_tx_enable_out_b ? '0 : tx_low_cnt + 1'b1;
   end

   sequence s_sel_hold;
      cell_tx_enable_out_b && (cell_tx_phy_address == tx_sel_q);
   endsequence
   sequence s_sel_release;
      !cell_tx_enable_out_b && $stable(cell_tx_phy_address);
   endsequence
   property p_tx_select;
      @(posedge cell_tx_clock) disable iff (!rst_b)
      (tx_state == TX_SELECT) && tx_mode_q |-> s_sel_hold ##1 s_sel_release;
   endproperty
   a_tx_select: assert property (p_tx_select) // see RULE3
      else $error("transmit select did not hold then drop enable");

   property p_tx_soc;
      @(posedge cell_tx_clock) disable iff (!rst_b)
      cell_tx_start_of_cell == $fell(cell_tx_enable_out_b);
   endproperty
   a_tx_soc: assert property (p_tx_soc) // see RULE6
      else $error("start of cell not on first byte only");

   property p_tx_send;
      @(posedge cell_tx_clock) disable iff (!rst_b)
      $fell(cell_tx_enable_out_b) |-> !cell_tx_enable_out_b [*8];
   endproperty
   a_tx_send: assert property (p_tx_send) // see RULE4 see RULE5
      else $error("transmit enable released early in a cell");

   property p_tx_len;
      @(posedge cell_tx_clock) disable iff (!rst_b)
      $rose(cell_tx_enable_out_b) |-> tx_low_cnt == (IDX_W+1)'(CELL_BYTES);
   endproperty
   a_tx_len: assert property (p_tx_len) // see RULE7
      else $error("transmit burst length differs from cell size");

   property p_tx_addr;
      @(posedge cell_tx_clock) disable iff (!rst_b)
      tx_mode_q && (tx_state != TX_IDLE) |->
         cell_tx_phy_address == tx_sel_q && !cell_tx_phy_address_oe_b;
   endproperty
   a_tx_addr: assert property (p_tx_addr) // see RULE8
      else $error("transmit address not the chosen PHY");

   property p_tx_clav;
      @(posedge cell_tx_clock) disable iff (!rst_b)
      $fell(cell_tx_enable_out_b) |-> $past(cell_tx_space_flag, 2);
   endproperty
   a_tx_clav: assert property (p_tx_clav) // see RULE16
      else $error("cell sent without space reported");

   property p_tx_idle_addr;
      @(posedge cell_tx_clock) disable iff (!rst_b)
      !tx_mode_q ##1 !tx_mode_q |-> cell_tx_phy_address == `UACP_IDLE_ADDR;
   endproperty
   a_tx_idle_addr: assert property (p_tx_idle_addr) // see RULE17
      else $error("transmit address moved outside MPHY mode");

   property p_rx_recv;
      @(posedge cell_rx_clock) disable iff (!rst_b)
      $fell(cell_rx_enable_out_b) && rx_mode_q |->
         cell_rx_phy_address == rx_sel_q &&
         $past(cell_rx_phy_address) == rx_sel_q;
   endproperty
   a_rx_recv: assert property (p_rx_recv) // see RULE13
      else $error("receive enable dropped for a PHY not chosen");

   property p_rx_clav;
      @(posedge cell_rx_clock) disable iff (!rst_b)
      $fell(cell_rx_enable_out_b) |-> $past(cell_rx_available_flag, 2);
   endproperty
   a_rx_clav: assert property (p_rx_clav) // see RULE14 see RULE16
      else $error("receive began without a cell reported");

   property p_rx_idle_addr;
      @(posedge cell_rx_clock) disable iff (!rst_b)
      !rx_mode_q ##1 !rx_mode_q |-> cell_rx_phy_address == `UACP_IDLE_ADDR;
   endproperty
   a_rx_idle_addr: assert property (p_rx_idle_addr) // see RULE17
      else $error("receive address moved outside MPHY mode");

endmodule

//--- sim/uacp_phy_model.sv
// Behavioural PHY set answering both directions of the cell port
`timescale 1ns/100ps

module uacp_phy_model
(
   // Transmit link
   input  wire logic       cell_tx_clock,
   input  wire logic       cell_tx_enable_out_b,
   input  wire logic       cell_tx_start_of_cell,
   input  wire logic [7:0] cell_tx_byte_bus,
   input  wire logic [4:0] cell_tx_phy_address,
   output logic            cell_tx_space_flag,
   // Receive link
   input  wire logic       cell_rx_clock,
   input  wire logic       cell_rx_enable_out_b,
   input  wire logic [4:0] cell_rx_phy_address,
   output logic            cell_rx_available_flag,
   output logic            cell_rx_start_of_cell,
   output logic [7:0]      cell_rx_byte_bus,
   // Bench control and observation
   input  wire logic       tx_room,
   input  wire logic       rx_full,
   input  wire logic [7:0] rx_seed,
   output logic [7:0]      tx_bytes [0:52],
   output int              tx_len,
   output int              tx_cells,
   output logic [4:0]      tx_addr_seen,
   output logic [4:0]      rx_addr_seen
);
   int rx_k;

   // Quiet start
   initial
   begin
      tx_len = 0;
      tx_cells = 0;
      rx_k = 0;
      cell_tx_space_flag = 1'b0;
      cell_rx_available_flag = 1'b0;
      cell_rx_start_of_cell = 1'b0;
      cell_rx_byte_bus = 8'h00;
   end

   // Every address answers with the same room level, one edge later;
   // a second start of cell restarts the count, so a stray one shows
   always @(posedge cell_tx_clock)
   begin
      cell_tx_space_flag <= tx_room;
      if (cell_tx_enable_out_b === 1'b0)
      begin
         if (cell_tx_start_of_cell === 1'b1)
         begin
            tx_len <= 1;
            tx_cells <= tx_cells + 1;
            tx_addr_seen <= cell_tx_phy_address;
            tx_bytes[0] <= cell_tx_byte_bus;
         end
         else
         begin
            tx_len <= tx_len + 1;
            if (tx_len < 53)
               tx_bytes[tx_len] <= cell_tx_byte_bus;
         end
      end
   end

   // Bytes follow the sampled enable; with no cell left the bus is
   // kept driven and toggles instead of holding the last byte
   always @(posedge cell_rx_clock)
   begin
      cell_rx_available_flag <= rx_full && rx_k == 0;
      if (!rx_full)
         rx_k <= 0;
      if (cell_rx_enable_out_b === 1'b0 && rx_full && rx_k < 53)
      begin
         if (rx_k == 0)
            rx_addr_seen <= cell_rx_phy_address;
         cell_rx_start_of_cell <= rx_k == 0;
         cell_rx_byte_bus <= rx_seed + 8'(rx_k);
         rx_k <= rx_k + 1;
      end
      else
      begin
         cell_rx_start_of_cell <= 1'b0;
         cell_rx_byte_bus <= ~cell_rx_byte_bus;
      end
   end

endmodule

//--- sim/test_uacp_port.sv
// Self-checking bench for the cell port against a behavioural PHY
`timescale 1ns/100ps

module test_uacp_port;

   // Ordinary cases: mode, addresses, data seed, then the addresses
   // that the PHYs should see with the first byte each way
   typedef struct {
      logic       mphy;
      logic [4:0] tx_sel;
      logic [4:0] rx_sel;
      logic [7:0] seed;
      logic [4:0] tx_addr;
      logic [4:0] rx_addr;
   } uacp_row_s;

   uacp_row_s rows [0:3] = '{
      '{1'b0, 5'h03, 5'h04, 8'h10, 5'h1F, 5'h1F},
      '{1'b1, 5'h00, 5'h1E, 8'h5A, 5'h00, 5'h1E},
      '{1'b1, 5'h1E, 5'h00, 8'hC3, 5'h1E, 5'h00},
      '{1'b1, 5'h0A, 5'h15, 8'hFF, 5'h0A, 5'h15}
   };

   // Design side
   logic       clock;
   logic       rst_b;
   logic       mphy_mode;
   logic [4:0] tx_phy_sel;
   logic [4:0] rx_phy_sel;
   logic       tx_wr_en;
   logic [5:0] tx_wr_addr;
   logic [7:0] tx_wr_byte;
   logic       tx_start;
   logic       tx_busy;
   logic       rx_start;
   logic       rx_busy;
   logic [5:0] rx_rd_addr;
   logic [7:0] rx_rd_byte;
   // Links
   logic       cell_tx_clock;
   logic       cell_tx_enable_out_b;
   logic       cell_tx_start_of_cell;
   logic [7:0] cell_tx_byte_bus;
   logic [4:0] cell_tx_phy_address;
   logic       cell_tx_phy_address_oe_b;
   logic       cell_tx_space_flag;
   logic       cell_rx_clock;
   logic       cell_rx_enable_out_b;
   logic [4:0] cell_rx_phy_address;
   logic       cell_rx_phy_address_oe_b;
   logic       cell_rx_available_flag;
   logic       cell_rx_start_of_cell;
   logic [7:0] cell_rx_byte_bus;
   // Model control and bench state
   logic       tx_room;
   logic       rx_full;
   logic [7:0] rx_seed;
   logic [7:0] tx_bytes [0:52];
   int         tx_len;
   int         tx_cells;
   logic [4:0] tx_addr_seen;
   logic [4:0] rx_addr_seen;
   int         fails = 0;
   int         n_checks = 0;
   int         cells = 0;
   int         cyc = 0;
   // Pin groups gathered for compact compares
   wire  [1:0] en_pair = {cell_tx_enable_out_b, cell_rx_enable_out_b};
   wire  [1:0] oe_pair = {cell_tx_phy_address_oe_b, cell_rx_phy_address_oe_b};
   wire  [5:0] tx_idle = {cell_tx_enable_out_b, cell_tx_phy_address};

   uacp_port uacp_port_inst
   (
      .clock, .rst_b, .mphy_mode, .tx_phy_sel, .rx_phy_sel, .tx_wr_en,
      .tx_wr_addr, .tx_wr_byte, .tx_start, .tx_busy, .rx_start, .rx_busy,
      .rx_rd_addr, .rx_rd_byte, .cell_tx_clock, .cell_tx_enable_out_b,
      .cell_tx_start_of_cell, .cell_tx_byte_bus, .cell_tx_phy_address,
      .cell_tx_phy_address_oe_b, .cell_tx_space_flag, .cell_rx_clock,
      .cell_rx_enable_out_b, .cell_rx_phy_address,
      .cell_rx_phy_address_oe_b, .cell_rx_available_flag,
      .cell_rx_start_of_cell, .cell_rx_byte_bus
   );

   uacp_phy_model uacp_phy_model_inst
   (
      .cell_tx_clock, .cell_tx_enable_out_b, .cell_tx_start_of_cell,
      .cell_tx_byte_bus, .cell_tx_phy_address, .cell_tx_space_flag,
      .cell_rx_clock, .cell_rx_enable_out_b, .cell_rx_phy_address,
      .cell_rx_available_flag, .cell_rx_start_of_cell, .cell_rx_byte_bus,
      .tx_room, .rx_full, .rx_seed, .tx_bytes, .tx_len, .tx_cells,
      .tx_addr_seen, .rx_addr_seen
   );

   // Clocks; the receive link clock is offset so none of its edges lines up with another
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   initial
   begin
      cell_tx_clock = 1'b0;
      forever #3 cell_tx_clock = ~cell_tx_clock;
   end

   initial
   begin
      cell_rx_clock = 1'b0;
      #1.7;
      forever #3 cell_rx_clock = ~cell_rx_clock;
   end

   task automatic close_out();
      if (fails == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Link outputs while reset is held
   task automatic check_reset();
      check("enables", 8'h03, 8'(en_pair));
      check("tx soc", 8'h00, 8'(cell_tx_start_of_cell));
      check("tx address", 8'h1F, 8'(cell_tx_phy_address));
      check("rx address", 8'h1F, 8'(cell_rx_phy_address));
      check("busy", 8'h00, 8'({tx_busy, rx_busy}));
      check("address oe", 8'h03, 8'(oe_pair));
   endtask

   // One cell each way; a stall keeps the PHYs unready for a while, with a
   // second transmit start given meanwhile that must be ignored
   task automatic run_cell(input uacp_row_s r, input int stall);
      int n;
      for (int k = 0; k < 53; k++)
      begin
         @(negedge clock);
         tx_wr_en = 1'b1;
         tx_wr_addr = 6'(k);
         tx_wr_byte = r.seed ^ 8'(k);
      end
      @(negedge clock);
      tx_wr_en = 1'b0;
      mphy_mode = r.mphy;
      tx_phy_sel = r.tx_sel;
      rx_phy_sel = r.rx_sel;
      rx_seed = ~r.seed;
      tx_room = stall == 0;
      rx_full = stall == 0;
      tx_start = 1'b1;
      rx_start = 1'b1;
      @(negedge clock);
      tx_start = 1'b0;
      rx_start = 1'b0;
      if (stall > 0)
      begin
         repeat (stall) @(negedge clock);
         tx_start = 1'b1;
         check("busy", 8'h03, 8'({tx_busy, rx_busy}));
         check("enables", 8'h03, 8'(en_pair));
         @(negedge clock);
         tx_start = 1'b0;
         tx_room = 1'b1;
         rx_full = 1'b1;
      end
      n = 0;
      while ((tx_busy !== 1'b0 || rx_busy !== 1'b0) && n < 3000)
      begin
         @(negedge clock);
         n++;
      end
      // A transfer that never ends shows up here, not only at the timeout
      check("busy end", 8'h00, 8'({tx_busy, rx_busy}));
      cells++;
      check("tx cells", 8'(cells), 8'(tx_cells));
      check("tx length", 8'h35, 8'(tx_len));
      check("tx addr", 8'(r.tx_addr), 8'(tx_addr_seen));
      check("rx addr", 8'(r.rx_addr), 8'(rx_addr_seen));
      check("idle tx", 8'h3F, 8'(tx_idle));
      for (int k = 0; k < 53; k++)
      begin
         check("tx byte", r.seed ^ 8'(k), tx_bytes[k]);
         rx_rd_addr = 6'(k);
         @(negedge clock);
         check("rx byte", rx_seed + 8'(k), rx_rd_byte);
      end
      rx_full = 1'b0;
   endtask

   // Cuts a hang short
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fails++;
         close_out();
      end
   end

   // Reset, table of cells, stalls, then a reset in mid-cell
   initial
   begin
      rst_b = 1'b0;
      {mphy_mode, tx_phy_sel, rx_phy_sel, tx_wr_en, tx_start} = '0;
      {tx_wr_addr, tx_wr_byte, rx_start, rx_rd_addr} = '0;
      {tx_room, rx_full, rx_seed} = '0;
      repeat (16) @(negedge clock);
      check_reset();
      rst_b = 1'b1;
      @(negedge clock);
      check("address oe", 8'h00, 8'(oe_pair));
      foreach (rows[i])
         run_cell(rows[i], 0);
      run_cell('{1'b1, 5'h07, 5'h08, 8'h3C, 5'h07, 5'h08}, 40);
      run_cell('{1'b0, 5'h07, 5'h08, 8'h81, 5'h1F, 5'h1F}, 40);
      tx_room = 1'b1;
      rx_full = 1'b1;
      tx_start = 1'b1;
      rx_start = 1'b1;
      @(negedge clock);
      tx_start = 1'b0;
      rx_start = 1'b0;
      repeat (4) @(negedge clock);
      rst_b = 1'b0;
      rx_full = 1'b0;
      @(negedge clock);
      check_reset();
      repeat (15) @(negedge clock);
      rst_b = 1'b1;
      cells = tx_cells;
      run_cell('{1'b1, 5'h11, 5'h12, 8'h66, 5'h11, 5'h12}, 0);
      close_out();
   end

endmodule
